/* File: rtl/wiper_consts.svh */
// Constants for the push-button wiper controller
`ifndef WIPER_CONSTS_SVH
`define WIPER_CONSTS_SVH
`define CLK_HZ 40000000
`define DEBOUNCE_MS 8
`define SCAN_START_MS 1000
`define SCAN_STEP_MS 140
`define IDLE_SAVE_MS 1000
`define NVM_WRITE_MS 20
`define MS_CYCLES(ms) ((ms) * (`CLK_HZ / 1000))
`define DEBOUNCE_CYC `MS_CYCLES(`DEBOUNCE_MS)
`define SCAN_START_CYC `MS_CYCLES(`SCAN_START_MS)
`define SCAN_STEP_CYC `MS_CYCLES(`SCAN_STEP_MS)
`define IDLE_SAVE_CYC `MS_CYCLES(`IDLE_SAVE_MS)
`define NVM_WRITE_CYC `MS_CYCLES(`NVM_WRITE_MS)
`define POS_W 6
`define POS_MID 6'h20
`define POS_MAX 6'h3F
`define POS_MIN 6'h00
`endif

/* File: rtl/wiper_pkg.sv */
// Types for the push-button wiper controller
package wiper_pkg;
	typedef struct packed
	{
		logic [5:0] code;
		logic bottom_scale_state;
		logic top_scale_state;
	} wiper_pos_t;

	typedef enum logic [1:0]
	{
		ST_LOAD,
		ST_RUN,
		ST_SAVE
	} ctrl_state_t;
endpackage

/* File: rtl/press_timer.sv */
// Debounce and auto-scan timer for one button
`timescale 1ns/10ps
`include "wiper_consts.svh"
module press_timer
	import wiper_pkg::*;
#(
	parameter int DEB_CYC = `DEBOUNCE_CYC,
	parameter int START_CYC = `SCAN_START_CYC,
	parameter int STEP_CYC = `SCAN_STEP_CYC
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic level,
	input wire logic lock,
	output logic step
);
	localparam int CW = $clog2(START_CYC + 2);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic scanning;
	logic next_scanning;
	logic next_step;

	always_comb
	begin
		next_count = count;
		next_scanning = scanning;
		next_step = 1'b0;
		if (!level || lock)
		begin
			// Short high pulses are dropped on release
			next_count = '0;
			next_scanning = 1'b0;
		end
		else if (!scanning)
		begin
			next_count = count + 1'b1;
			if (count == CW'(DEB_CYC))
				next_step = 1'b1;
			if (count == CW'(START_CYC))
			begin
				next_scanning = 1'b1;
				next_step = 1'b1;
				next_count = '0;
			end
		end
		else
		begin
			next_count = count + 1'b1;
			if (count == CW'(STEP_CYC - 1))
			begin
				next_step = 1'b1;
				next_count = '0;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			count <= '0;
			scanning <= 1'b0;
			step <= 1'b0;
		end
		else
		begin
			count <= next_count;
			scanning <= next_scanning;
			step <= next_step;
		end
	end

	a_single_step: assert property (@(posedge clk) disable iff (!rst_n)
		step && !scanning |=> !step)
		else $error("step pulse longer than one cycle");
	a_drop_short: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(level) |-> !step)
		else $error("step without a held press");
endmodule

/* File: rtl/nvm_cell.sv */
// Nonvolatile position store with registered read data
`timescale 1ns/10ps
`include "wiper_consts.svh"
module nvm_cell
	import wiper_pkg::*;
#(
	parameter wiper_pos_t INIT = '{code: `POS_MID, bottom_scale_state: 1'b0, top_scale_state: 1'b0}
)
(
	input wire logic clk,
	input wire logic wr_en,
	input wire wiper_pos_t wr_data,
	output wiper_pos_t rd_data
);
	// Contents survive reset; initial value stands in for the factory image
	wiper_pos_t mem = INIT;
	wiper_pos_t next_mem;
	wiper_pos_t rd_reg = INIT;

	always_comb
	begin
		next_mem = wr_en ? wr_data : mem;
	end

	always_ff @(posedge clk)
	begin
		mem <= next_mem;
		rd_reg <= mem;
	end

	assign rd_data = rd_reg;
endmodule

/* File: rtl/pushbutton_wiper_stepper.sv */
// Push-button wiper position controller with save and restore
//
// Function
// - Both buttons active high
// - Save mode latched once at power-up
// - Save pin flags end scale when auto
// - Position code selects tap, 0x20 mid
// - High intervals under 8 ms ignored
// - Held over 8 ms steps once
// - Held over 1 s repeats every 140 ms
// - Down button mirrors up button
// - Step past end loads extra state
// - Bottom scale ignores further down
// - Top scale ignores further up
// - Save lasts 20 ms, input locked
// - Power-up restores stored position
// - Six-bit code, 64 taps
// - Auto save after 1 s idle
// - Manual save on 8 ms low pin
// - Drive pin high at end while pushing
`timescale 1ns/10ps
`include "wiper_consts.svh"
module pushbutton_wiper_stepper
	import wiper_pkg::*;
#(
	parameter int DEB_CYC = `DEBOUNCE_CYC,
	parameter int START_CYC = `SCAN_START_CYC,
	parameter int STEP_CYC = `SCAN_STEP_CYC,
	parameter int IDLE_CYC = `IDLE_SAVE_CYC,
	parameter int WRITE_CYC = `NVM_WRITE_CYC
)
(
	input wire logic MCLK,
	input wire logic RSTN,
	input wire logic STEP_UP_BUTTON,
	input wire logic STEP_DOWN_BUTTON,
	input wire logic SAVE_ENABLE_N_IN,
	output logic SAVE_ENABLE_N_OUT,
	output logic SAVE_ENABLE_N_OE,
	output logic [`POS_W-1:0] WIPER_POSITION_REGISTER,
	output logic BOTTOM_SCALE_STATE,
	output logic TOP_SCALE_STATE,
	output logic SAVE_BUSY
);
	localparam int IW = $clog2(IDLE_CYC + 2);
	localparam int WW = $clog2(WRITE_CYC + 2);
	localparam int DW = $clog2(DEB_CYC + 2);

	logic rst_meta;
	logic rst_n;
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic up_lvl;
	logic down_lvl;
	logic save_lvl_n;
	logic up_step;
	logic down_step;
	logic lock;

	ctrl_state_t state;
	ctrl_state_t next_state;
	wiper_pos_t pos;
	wiper_pos_t next_pos;
	wiper_pos_t nvm_rd;
	logic auto_save;
	logic next_auto_save;
	logic strap_taken;
	logic next_strap_taken;
	logic [IW-1:0] idle_cnt;
	logic [IW-1:0] next_idle_cnt;
	logic [WW-1:0] write_cnt;
	logic [WW-1:0] next_write_cnt;
	logic [DW-1:0] man_cnt;
	logic [DW-1:0] next_man_cnt;
	logic dirty;
	logic next_dirty;
	logic end_flag;
	logic next_end_flag;
	logic nvm_wr;

	// Reset release through two flip-flops
	always_ff @(posedge MCLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Input synchronizers run through reset so the strap is settled at load
	always_ff @(posedge MCLK)
	begin
		sync_a <= {SAVE_ENABLE_N_IN, STEP_DOWN_BUTTON, STEP_UP_BUTTON};
		sync_b <= sync_a;
	end

	assign up_lvl = sync_b[0];
	assign down_lvl = sync_b[1];
	assign save_lvl_n = sync_b[2];
	assign lock = (state != ST_RUN);

	press_timer #(
		.DEB_CYC(DEB_CYC),
		.START_CYC(START_CYC),
		.STEP_CYC(STEP_CYC)
	) u_up_timer (
		.clk(MCLK),
		.rst_n(rst_n),
		.level(up_lvl),
		.lock(lock),
		.step(up_step)
	);

	press_timer #(
		.DEB_CYC(DEB_CYC),
		.START_CYC(START_CYC),
		.STEP_CYC(STEP_CYC)
	) u_down_timer (
		.clk(MCLK),
		.rst_n(rst_n),
		.level(down_lvl),
		.lock(lock),
		.step(down_step)
	);

	nvm_cell u_nvm (
		.clk(MCLK),
		.wr_en(nvm_wr),
		.wr_data(pos),
		.rd_data(nvm_rd)
	);

	always_comb
	begin
		next_state = state;
		next_pos = pos;
		next_auto_save = auto_save;
		next_strap_taken = strap_taken;
		next_idle_cnt = idle_cnt;
		next_write_cnt = write_cnt;
		next_man_cnt = man_cnt;
		next_dirty = dirty;
		next_end_flag = end_flag;
		nvm_wr = 1'b0;
		unique case (state)
			ST_LOAD:
			begin
				next_pos = nvm_rd;
				if (!strap_taken)
				begin
					next_auto_save = !save_lvl_n;
					next_strap_taken = 1'b1;
				end
				next_state = ST_RUN;
			end
			ST_RUN:
			begin
				if (up_step && !down_step)
				begin
					next_dirty = 1'b1;
					if (pos.bottom_scale_state)
						next_pos.bottom_scale_state = 1'b0;
					else if (pos.top_scale_state)
						next_pos = pos;
					else if (pos.code == `POS_MAX)
						next_pos.top_scale_state = 1'b1;
					else
						next_pos.code = pos.code + 1'b1;
				end
				else if (down_step && !up_step)
				begin
					next_dirty = 1'b1;
					if (pos.top_scale_state)
						next_pos.top_scale_state = 1'b0;
					else if (pos.bottom_scale_state)
						next_pos = pos;
					else if (pos.code == `POS_MIN)
						next_pos.bottom_scale_state = 1'b1;
					else
						next_pos.code = pos.code - 1'b1;
				end
				// End flag held while pushing toward the reached end
				next_end_flag = (next_pos.top_scale_state && up_lvl)
					|| (next_pos.bottom_scale_state && down_lvl);
				if (up_lvl || down_lvl)
					next_idle_cnt = '0;
				else if (idle_cnt != IW'(IDLE_CYC))
					next_idle_cnt = idle_cnt + 1'b1;
				if (!auto_save && !save_lvl_n)
				begin
					if (man_cnt != DW'(DEB_CYC))
						next_man_cnt = man_cnt + 1'b1;
				end
				else
					next_man_cnt = '0;
				if (auto_save && dirty && idle_cnt == IW'(IDLE_CYC))
				begin
					nvm_wr = 1'b1;
					next_state = ST_SAVE;
				end
				else if (!auto_save && man_cnt == DW'(DEB_CYC - 1))
				begin
					nvm_wr = 1'b1;
					next_state = ST_SAVE;
				end
				if (nvm_wr)
				begin
					next_dirty = 1'b0;
					next_write_cnt = '0;
					next_end_flag = 1'b0;
				end
			end
			ST_SAVE:
			begin
				next_write_cnt = write_cnt + 1'b1;
				if (write_cnt == WW'(WRITE_CYC - 1))
				begin
					next_state = ST_RUN;
					next_idle_cnt = '0;
				end
			end
			default:
				next_state = ST_LOAD;
		endcase
	end

	always_ff @(posedge MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= ST_LOAD;
			pos <= '{code: `POS_MID, bottom_scale_state: 1'b0, top_scale_state: 1'b0};
			auto_save <= 1'b0;
			strap_taken <= 1'b0;
			idle_cnt <= '0;
			write_cnt <= '0;
			man_cnt <= '0;
			dirty <= 1'b0;
			end_flag <= 1'b0;
		end
		else
		begin
			state <= next_state;
			pos <= next_pos;
			auto_save <= next_auto_save;
			strap_taken <= next_strap_taken;
			idle_cnt <= next_idle_cnt;
			write_cnt <= next_write_cnt;
			man_cnt <= next_man_cnt;
			dirty <= next_dirty;
			end_flag <= next_end_flag;
		end
	end

	assign WIPER_POSITION_REGISTER = pos.code;
	assign BOTTOM_SCALE_STATE = pos.bottom_scale_state;
	assign TOP_SCALE_STATE = pos.top_scale_state;
	assign SAVE_BUSY = (state == ST_SAVE);
	assign SAVE_ENABLE_N_OUT = 1'b1;
	assign SAVE_ENABLE_N_OE = auto_save && end_flag;

	a_save_locks: assert property (@(posedge MCLK) disable iff (!rst_n)
		state == ST_SAVE |=> $stable(pos))
		else $error("position changed during save");
	a_save_length: assert property (@(posedge MCLK) disable iff (!rst_n)
		$rose(SAVE_BUSY) |-> SAVE_BUSY [*8])
		else $error("save ended too early");
	a_top_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
		pos.top_scale_state && !down_step |=> pos.top_scale_state)
		else $error("top scale left without down step");
	a_bottom_hold: assert property (@(posedge MCLK) disable iff (!rst_n)
		pos.bottom_scale_state && !up_step |=> pos.bottom_scale_state)
		else $error("bottom scale left without up step");
	a_up_count: assert property (@(posedge MCLK) disable iff (!rst_n)
		state == ST_RUN && up_step && !down_step && !pos.top_scale_state
		&& !pos.bottom_scale_state && pos.code != `POS_MAX
		|=> pos.code == $past(pos.code) + 6'h01)
		else $error("up step did not add one");
	a_down_count: assert property (@(posedge MCLK) disable iff (!rst_n)
		state == ST_RUN && down_step && !up_step && !pos.top_scale_state
		&& !pos.bottom_scale_state && pos.code != `POS_MIN
		|=> pos.code == $past(pos.code) - 6'h01)
		else $error("down step did not subtract one");
	a_top_enter: assert property (@(posedge MCLK) disable iff (!rst_n)
		state == ST_RUN && up_step && !down_step && pos.code == `POS_MAX
		&& !pos.bottom_scale_state |=> pos.top_scale_state)
		else $error("top scale not entered");
	a_pin_drive: assert property (@(posedge MCLK) disable iff (!rst_n)
		SAVE_ENABLE_N_OE |-> auto_save && (pos.top_scale_state || pos.bottom_scale_state))
		else $error("save pin driven without end scale");
	a_restore: assert property (@(posedge MCLK) disable iff (!rst_n)
		state == ST_LOAD |=> pos == $past(nvm_rd))
		else $error("position not restored");
	a_strap_take: assert property (@(posedge MCLK) disable iff (!rst_n)
		state == ST_LOAD && !strap_taken |=> auto_save == !$past(save_lvl_n))
		else $error("save mode not taken from strap");
endmodule

/* File: tb/button_pad.sv */
// Push-button and pull-resistor model facing the wiper controller
`timescale 1ns/10ps
module button_pad
(
	input wire logic up_press,
	input wire logic down_press,
	input wire logic save_press,
	input wire logic strap_high,
	input wire logic pin_oe,
	input wire logic pin_out,
	output logic up_level,
	output logic down_level,
	output logic pin_level
);
	// Closed switch reads high, open one falls to the pad pull-down
	assign up_level = up_press;
	assign down_level = down_press;
	// Device drive wins, then the save switch, then the strap resistor
	assign pin_level = pin_oe ? pin_out : (save_press ? 1'b0 : strap_high);
endmodule

/* File: tb/test_pushbutton_wiper_stepper.sv */
// Self-checking bench for the push-button wiper controller
`timescale 1ns/10ps
module test_pushbutton_wiper_stepper;
	import wiper_pkg::*;
	localparam int DEB = 20;
	localparam int START = 200;
	localparam int STEP = 30;
	localparam int IDLE = 100;
	localparam int WR = 40;
	logic mclk = 0, rstn = 0, up = 0, dn = 0, sv = 0, strap = 1, end_oe = 0;
	logic up_lvl, dn_lvl, pin, oe, pout, bot, top, busy;
	logic [5:0] pos;
	int failures = 0, n_compared = 0, seed = 10991, i;
	int code = 32, mtop = 0, mbot = 0, icode = 32, itop = 0, ibot = 0;
	int busy_cnt = 0, busy_len = 0, n_saves = 0;

	always #12.5 mclk = ~mclk;

	pushbutton_wiper_stepper #(.DEB_CYC(DEB), .START_CYC(START), .STEP_CYC(STEP),
		.IDLE_CYC(IDLE), .WRITE_CYC(WR)) u_dut (.MCLK(mclk), .RSTN(rstn),
		.STEP_UP_BUTTON(up_lvl), .STEP_DOWN_BUTTON(dn_lvl), .SAVE_ENABLE_N_IN(pin),
		.SAVE_ENABLE_N_OUT(pout), .SAVE_ENABLE_N_OE(oe), .WIPER_POSITION_REGISTER(pos),
		.BOTTOM_SCALE_STATE(bot), .TOP_SCALE_STATE(top), .SAVE_BUSY(busy));

	button_pad u_pad (.up_press(up), .down_press(dn), .save_press(sv), .strap_high(strap),
		.pin_oe(oe), .pin_out(pout), .up_level(up_lvl), .down_level(dn_lvl), .pin_level(pin));

	// Save length and count, sampled where the outputs are settled
	always @(negedge mclk)
	begin
		if (busy === 1'b1)
		begin
			if (busy_cnt == 0)
				n_saves++;
			busy_cnt++;
		end
		else if (busy_cnt != 0)
		begin
			busy_len = busy_cnt;
			busy_cnt = 0;
		end
	end

	task report_and_stop;
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task check_pos;
		check({pos, bot, top}, {code[5:0], mbot[0], mtop[0]});
	endtask

	task mstep(input int d);
		if (d && mbot)
			mbot = 0;
		else if (d && code == 63)
			mtop = 1;
		else if (d && !mtop)
			code++;
		else if (!d && mtop)
			mtop = 0;
		else if (!d && code == 0)
			mbot = 1;
		else if (!d && !mbot)
			code--;
	endtask

	task hold(input int d, input int n);
		int k;
		@(negedge mclk);
		up = d;
		dn = !d;
		repeat (n) @(negedge mclk);
		end_oe = oe;
		up = 0;
		dn = 0;
		repeat (10) @(negedge mclk);
		k = (n < DEB + 4) ? 0 : 1 + ((n > START + 4) ? (n - START - 4) / STEP + 1 : 0);
		repeat (k) mstep(d);
	endtask

	task do_reset(input logic s);
		@(negedge mclk);
		strap = s;
		rstn = 0;
		repeat (4) @(negedge mclk);
		rstn = 1;
		repeat (8) @(negedge mclk);
		code = icode;
		mtop = itop;
		mbot = ibot;
	endtask

	task wait_save;
		int s0;
		s0 = n_saves;
		repeat (IDLE + WR + 40) @(negedge mclk);
		check(8'(n_saves - s0), 8'h01);
		check(8'(busy_len), 8'(WR));
		icode = code;
		itop = mtop;
		ibot = mbot;
	endtask

	initial
	begin
		#2000000;
		failures++;
		report_and_stop;
	end

	initial
	begin
		do_reset(1);
		check_pos;
		check({6'h00, busy, oe}, 8'h00);
		check({7'h00, pout}, 8'h01);
		repeat (4) hold(1, ($unsigned($random(seed)) % 15) + 1);
		check_pos;
		hold(1, 40);
		check_pos;
		hold(0, 40);
		hold(0, 40);
		check_pos;
		hold(1, START + 3 * STEP + 15);
		check_pos;
		hold(0, START + 3 * STEP + 15);
		check_pos;
		hold(1, 2300);
		check_pos;
		check({7'h00, end_oe}, 8'h00);
		hold(0, 40);
		check_pos;
		hold(0, 2300);
		check_pos;
		hold(1, 40);
		hold(1, 40);
		check_pos;
		// Manual save, with a press landing inside the write
		@(negedge mclk);
		sv = 1;
		for (i = 0; i < DEB + 10 && busy !== 1'b1; i++)
			@(negedge mclk);
		check({7'h00, busy}, 8'h01);
		sv = 0;
		up = 1;
		repeat (30) @(negedge mclk);
		up = 0;
		repeat (30) @(negedge mclk);
		check_pos;
		check(8'(busy_len), 8'(WR));
		icode = code;
		do_reset(0);
		check_pos;
		hold(1, 40);
		wait_save;
		check_pos;
		hold(1, 2300);
		check({7'h00, end_oe}, 8'h01);
		check({7'h00, oe}, 8'h00);
		wait_save;
		do_reset(0);
		check_pos;
		report_and_stop;
	end
endmodule
